/* inc/hpc_consts.svh */
// constants for the host port control-two register bank
// assumes inclusion by bare name from inc/
`ifndef HPC_CONSTS_SVH
`define HPC_CONSTS_SVH

// register addresses on the host port
`define HPC_ADDR_CTRL2      5'h01
`define HPC_ADDR_STATUS     5'h03
`define HPC_ADDR_CFG_DATA   5'h04

// control-two field positions
`define HPC_BIT_CFG_IRQ_EN  0
`define HPC_BIT_ERR_IRQ_EN  1
`define HPC_BIT_USR_IRQ_EN  2
`define HPC_BIT_CHAIN_EN    3
`define HPC_BIT_HOLD_BUS    4
`define HPC_BIT_USER_MODE   5
`define HPC_CTRL2_MASK      8'h3f
`define HPC_CTRL2_RESET     8'h00

// status field positions
`define HPC_STS_DATA_READY  1
`define HPC_STS_IRQ_PEND    2
`define HPC_STS_ERR_LO      3
`define HPC_STS_ERR_HI      4
`define HPC_STS_INIT        6
`define HPC_STS_DONE        7
`define HPC_ERR_NONE        2'h0

`endif

/* inc/hpc_pkg.sv */
// types for the host port control-two register bank
// assumes hpc_consts.svh on the include path
`default_nettype none
package hpc_pkg;

	// host bus request as seen at the port
	typedef struct packed {
		logic       sel;
		logic       wr;
		logic [4:0] addr;
		logic [7:0] wdata;
	} hpc_req_t;

	// decoded control-two fields
	typedef struct packed {
		logic cfg_irq_en;
		logic err_irq_en;
		logic usr_irq_en;
		logic chain_en;
		logic hold_bus;
		logic user_mode;
	} hpc_ctrl_t;

	typedef enum logic [1:0] {
		HPC_IDLE,
		HPC_HOLD,
		HPC_ACK
	} hpc_state_t;

endpackage

`default_nettype wire

/* rtl/hpc_ctrl2.sv */
// host port control-two register, status read path and interrupt combine
// assumes host bus in core_clk domain; pins from outside pass hpc_sync
//
// Operation
// - reading control two returns bits five to zero last written; bits six and seven read zero
// - config-data enable raises irq on each byte request or availability
// - config-data irq only acts during chained configuration
// - stream-error enable raises irq on a bit stream error
// - stream-error enable only acts while configuring
// - user-logic enable forwards irq while user request line is low
// - chain enable passes configuration data to the chained output
// - hold-bus delays config-data write ack until byte serialized
// - serialization, hence holding, happens only with chain enable set
// - without hold-bus, config-data writes acknowledge at once
// - user-mode enable keeps the port usable after configuration
// - bit stream may also enable user mode independently
// - reset clears control bits zero through five
// - status register is read-only; writes are ignored
// - stream errors are held in status bits four to three
// - data-ready clears on any config-data register access
`timescale 1ns/100ps
`default_nettype none
`include "hpc_consts.svh"

module hpc_ctrl2 (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              nrst,
	// host bus, request held until ack
	input  wire hpc_pkg::hpc_req_t host_req,
	output var  logic              host_ack,
	output var  logic [7:0]        host_rdata,
	output logic                   host_irq,
	// configuration engine
	input  wire logic              cfg_mode,
	input  wire logic              cfg_chain_mode,
	input  wire logic              cfg_byte_req,
	input  wire logic              cfg_err_event,
	input  wire logic [1:0]        cfg_err_code,
	input  wire logic              cfg_serial_done,
	input  wire logic              cfg_stream_user_mode,
	input  wire logic              prog_active,
	output var  logic              cfg_byte_valid,
	output var  logic [7:0]        cfg_byte,
	output logic                   chain_output_enable,
	output logic                   hold_bus_until_serialized,
	// user logic and pins
	input  wire logic              user_irq_request_n,
	input  wire logic              init_pin,
	input  wire logic              done_pin,
	output logic                   user_mode_enable,
	output logic                   port_user_active
);

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic user_irq_n_s;
	logic init_s;
	logic done_s;

	hpc_sync #(.RESET_VAL(1'b1)) u_sync_user_irq_request_n (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in (user_irq_request_n),
		.sync_out (user_irq_n_s)
	);

	hpc_sync #(.RESET_VAL(1'b0)) u_sync_init (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in (init_pin),
		.sync_out (init_s)
	);

	hpc_sync #(.RESET_VAL(1'b0)) u_sync_done (
		.core_clk (core_clk),
		.nrst     (nrst),
		.async_in (done_pin),
		.sync_out (done_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode

	logic [7:0]         ctrl2;
	hpc_pkg::hpc_ctrl_t ctrl;
	logic               data_ready;
	logic               irq_pending;
	logic [1:0]         err_code;
	hpc_pkg::hpc_state_t state;
	hpc_pkg::hpc_state_t next_state;

	wire hit_ctrl2  = host_req.sel && (host_req.addr == `HPC_ADDR_CTRL2);
	wire hit_status = host_req.sel && (host_req.addr == `HPC_ADDR_STATUS);
	wire hit_data   = host_req.sel && (host_req.addr == `HPC_ADDR_CFG_DATA);
	wire wr_ctrl2   = hit_ctrl2 && host_req.wr && (state == hpc_pkg::HPC_IDLE);
	wire wr_data    = hit_data && host_req.wr && (state == hpc_pkg::HPC_IDLE);
	wire rd_status  = hit_status && !host_req.wr && (state == hpc_pkg::HPC_IDLE);
	wire acc_data   = hit_data && (state == hpc_pkg::HPC_IDLE);

	assign ctrl.cfg_irq_en = ctrl2[`HPC_BIT_CFG_IRQ_EN];
	assign ctrl.err_irq_en = ctrl2[`HPC_BIT_ERR_IRQ_EN];
	assign ctrl.usr_irq_en = ctrl2[`HPC_BIT_USR_IRQ_EN];
	assign ctrl.chain_en   = ctrl2[`HPC_BIT_CHAIN_EN];
	assign ctrl.hold_bus   = ctrl2[`HPC_BIT_HOLD_BUS];
	assign ctrl.user_mode  = ctrl2[`HPC_BIT_USER_MODE];

	assign chain_output_enable       = ctrl.chain_en;
	assign hold_bus_until_serialized = ctrl.hold_bus;
	assign user_mode_enable          = ctrl.user_mode;
	// user mode from register or bit stream, live only once done is seen
	assign port_user_active = (ctrl.user_mode || cfg_stream_user_mode) && done_s;

	////////////////////////////////////////////////////////////////////////////
	// interrupt sources

	wire cfg_irq = ctrl.cfg_irq_en && cfg_mode && cfg_chain_mode && data_ready;
	wire err_irq = ctrl.err_irq_en && cfg_mode && cfg_err_event;
	wire usr_irq = ctrl.usr_irq_en && !user_irq_n_s;
	wire any_irq = cfg_irq || err_irq || usr_irq;

	// level output: stays while a source is active or the pending flag is up
	assign host_irq = any_irq || irq_pending;

	////////////////////////////////////////////////////////////////////////////
	// control-two register

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl2 <= `HPC_CTRL2_RESET;
		end else if (wr_ctrl2) begin
			ctrl2 <= host_req.wdata & `HPC_CTRL2_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status flags; set wins over clear

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			data_ready  <= 1'b0;
			irq_pending <= 1'b0;
		end else begin
			data_ready  <= cfg_byte_req || (data_ready && !acc_data);
			irq_pending <= any_irq || (irq_pending && !rd_status);
		end
	end

	// error code cleared by program, captured on error events
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			err_code <= `HPC_ERR_NONE;
		end else if (cfg_err_event && cfg_mode) begin
			err_code <= cfg_err_code;
		end else if (prog_active) begin
			err_code <= `HPC_ERR_NONE;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// config-data write handshake

	// hold only meaningful when chained output serializes the byte
	wire need_hold = ctrl.hold_bus && ctrl.chain_en;

	always_comb begin
		next_state = state;
		unique case (state)
			hpc_pkg::HPC_IDLE: begin
				if (host_req.sel && !(wr_data && need_hold)) begin
					next_state = hpc_pkg::HPC_ACK;
				end else if (wr_data) begin
					next_state = hpc_pkg::HPC_HOLD;
				end
			end
			hpc_pkg::HPC_HOLD: begin
				if (cfg_serial_done) begin
					next_state = hpc_pkg::HPC_ACK;
				end
			end
			hpc_pkg::HPC_ACK: begin
				next_state = hpc_pkg::HPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state <= hpc_pkg::HPC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign host_ack = (state == hpc_pkg::HPC_ACK);

	// byte handed to the configuration engine for one cycle
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_byte_valid <= 1'b0;
			cfg_byte       <= 8'h00;
		end else begin
			cfg_byte_valid <= wr_data;
			if (wr_data) begin
				cfg_byte <= host_req.wdata;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data; status writes fall through with no effect

	logic [7:0] status_val;
	always_comb begin
		status_val = 8'h00;
		status_val[`HPC_STS_DATA_READY] = data_ready;
		status_val[`HPC_STS_IRQ_PEND]   = irq_pending;
		status_val[`HPC_STS_ERR_HI:`HPC_STS_ERR_LO] = err_code;
		status_val[`HPC_STS_INIT]       = init_s;
		status_val[`HPC_STS_DONE]       = done_s;
	end

	wire rd_any = host_req.sel && !host_req.wr && (state == hpc_pkg::HPC_IDLE);
	wire [7:0] rd_mux = hit_ctrl2  ? ctrl2 :
	                    hit_status ? status_val : 8'h00;

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			host_rdata <= 8'h00;
		end else if (rd_any) begin
			host_rdata <= rd_mux;
		end
	end

endmodule

`default_nettype wire

/* rtl/hpc_sync.sv */
// three-stage input synchroniser with agreement filter
// assumes async level inputs, one core clock domain
`timescale 1ns/100ps
`default_nettype none

module hpc_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	// async level in, filtered level out
	input  wire logic async_in,
	output var  logic sync_out
);

	logic s1;
	logic s2;
	logic s3;

	// second and third agree before the output follows
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			s1       <= RESET_VAL;
			s2       <= RESET_VAL;
			s3       <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3) begin
				sync_out <= s3;
			end
		end
	end

endmodule

`default_nettype wire

/* test/hpc_ctrl2_asserts.sv */
// port checker for the control-two bank
// assumes bound into hpc_ctrl2, hosts hold sel until ack
`timescale 1ns/100ps
`default_nettype none
module hpc_ctrl2_asserts (
	// clock and reset
	input wire logic              core_clk,
	input wire logic              nrst,
	// host side
	input wire hpc_pkg::hpc_req_t host_req,
	input wire logic              host_ack,
	input wire logic [7:0]        host_rdata,
	input wire logic              host_irq,
	// engine and user side
	input wire logic              cfg_mode,
	input wire logic              cfg_err_event,
	input wire logic              cfg_serial_done,
	input wire logic              cfg_stream_user_mode,
	input wire logic              chain_output_enable,
	input wire logic              hold_bus_until_serialized,
	input wire logic              user_mode_enable,
	input wire logic              port_user_active,
	input wire logic              user_irq_request_n
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);
	logic       usr_en;
	logic       err_en;
	wire  logic wr_ctrl = host_ack && host_req.sel && host_req.wr && host_req.addr == 5'h01;
	wire  logic held = host_req.wr && host_req.addr == 5'h04 && hold_bus_until_serialized && chain_output_enable;
	wire  logic [2:0] outs = {user_mode_enable, hold_bus_until_serialized, chain_output_enable};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst)
			{usr_en, err_en} <= 2'h0;
		else if (wr_ctrl)
			{usr_en, err_en} <= host_req.wdata[2:1];
	end
	ctrl_write_a: assert property (wr_ctrl |-> outs == host_req.wdata[5:3])
		else $error("control bits differ from write");
	read_back_a: assert property (host_ack && !host_req.wr && host_req.addr == 5'h01 |->
		host_rdata[7:3] == {2'h0, outs}) else $error("control read back wrong");
	reset_clear_a: assert property ($rose(nrst) |-> outs == 3'h0) else $error("control bits set after reset");
	usr_irq_a: assert property ((usr_en && !user_irq_request_n)[*8] |-> host_irq) else $error("user irq lost");
	err_irq_a: assert property (cfg_err_event && err_en && cfg_mode |-> ##[0:2] host_irq)
		else $error("error irq lost");
	hold_ack_a: assert property (host_ack && held |-> $past(cfg_serial_done)) else $error("held ack too early");
	quick_ack_a: assert property ($rose(host_req.sel) && !host_ack && !held |=> host_ack)
		else $error("ack not immediate");
	status_ro_a: assert property (host_ack && host_req.wr && host_req.addr == 5'h03 |-> $stable(outs))
		else $error("status write changed control");
	user_port_a: assert property (port_user_active |-> user_mode_enable || cfg_stream_user_mode)
		else $error("port active without enable");
	cover property (wr_ctrl);
	cover property (host_ack && held);
	cover property (host_irq);
endmodule
bind hpc_ctrl2 hpc_ctrl2_asserts u_chk (.*);
`default_nettype wire

/* test/hpc_host_model.sv */
// host processor model: one byte transfer at a time
// assumes one core clock; changes only after rising edges
`timescale 1ns/100ps
`default_nettype none
module hpc_host_model (
	// clock
	input  wire logic              core_clk,
	// answer
	input  wire logic              host_ack,
	input  wire logic [7:0]        host_rdata,
	// request
	output var  hpc_pkg::hpc_req_t host_req
);
	initial host_req = '0;
	task automatic xfer(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
		host_req <= '{1'b1, w, a, d};
		// no local limit: a missing ack runs into the bench timeout
		do begin
			@(posedge core_clk);
		end while (host_ack !== 1'b1);
		q = host_rdata;
		// released bus shows the inverse, not a stale copy
		host_req <= '{1'b0, ~w, ~a, ~d};
		@(posedge core_clk);
	endtask
endmodule
`default_nettype wire

/* test/tb_host_port_control_two.sv */
// testbench for the control-two bank
// assumes the host model and checker files compile first
`timescale 1ns/100ps
`default_nettype none
module tb_host_port_control_two;
	logic              core_clk;
	logic              nrst = 0;
	logic              cfg_mode = 0;
	logic              cfg_err_event = 0;
	logic              cfg_serial_done = 0;
	logic              cfg_stream_user_mode = 0;
	logic              user_irq_request_n = 1;
	logic              done_pin = 0;
	logic              cfg_chain_mode = 1;
	logic              cfg_byte_req = 0;
	logic              prog_active = 0;
	logic              init_pin = 0;
	logic [1:0]        cfg_err_code = 2'h0;
	logic [7:0]        q;
	logic [7:0]        got_byte;
	logic [7:0]        cfg_byte;
	logic              host_ack;
	logic              host_irq;
	logic              cfg_byte_valid;
	logic              chain;
	logic              hold;
	logic              umode;
	logic              port_user_active;
	logic [7:0]        host_rdata;
	hpc_pkg::hpc_req_t host_req;
	int                mismatches = 0;
	int                n_tests = 0;
	int                cyc = 0;
	int                t0;
	hpc_host_model host (.core_clk(core_clk), .host_ack(host_ack), .host_rdata(host_rdata), .host_req(host_req));
	hpc_ctrl2 dut (.core_clk(core_clk), .nrst(nrst), .host_req(host_req), .host_ack(host_ack),
		.host_rdata(host_rdata), .host_irq(host_irq), .cfg_mode(cfg_mode), .cfg_chain_mode(cfg_chain_mode),
		.cfg_byte_req(cfg_byte_req), .cfg_err_event(cfg_err_event), .cfg_err_code(cfg_err_code),
		.cfg_serial_done(cfg_serial_done), .cfg_stream_user_mode(cfg_stream_user_mode),
		.prog_active(prog_active), .cfg_byte_valid(cfg_byte_valid), .cfg_byte(cfg_byte),
		.chain_output_enable(chain), .hold_bus_until_serialized(hold),
		.user_irq_request_n(user_irq_request_n), .init_pin(init_pin),
		.done_pin(done_pin), .user_mode_enable(umode), .port_user_active(port_user_active));
	initial begin
		core_clk = 0;
		forever #2 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		// non-blocking so tasks reading cyc at the edge see one stable count
		cyc <= cyc + 1;
		if (cfg_byte_valid)
			got_byte <= cfg_byte;
		if (cyc == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		host.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		host.xfer(1'b0, a, 8'h00, q);
		check(q, exp);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		rd(5'h01, 8'h00);
		wr(5'h01, 8'hff);
		rd(5'h01, 8'h3f);
		check({5'h0, umode, hold, chain}, 8'h07);
		wr(5'h03, 8'hff);
		rd(5'h01, 8'h3f);
		rd(5'h03, 8'h00);
		wr(5'h01, 8'h00);
	endtask
	task automatic t_irq();
		user_irq_request_n <= 0;
		repeat (8) @(posedge core_clk);
		check({7'h0, host_irq}, 8'h00);
		wr(5'h01, 8'h06);
		check({7'h0, host_irq}, 8'h01);
		user_irq_request_n <= 1;
		repeat (8) @(posedge core_clk);
		cfg_mode <= 1;
		host.xfer(1'b0, 5'h03, 8'h00, q);
		cfg_err_event <= 1;
		cfg_err_code <= 2'h2;
		@(posedge core_clk);
		cfg_err_event <= 0;
		repeat (3) @(posedge core_clk);
		check({7'h0, host_irq}, 8'h01);
		host.xfer(1'b0, 5'h03, 8'h00, q);
		check({6'h0, q[4:3]}, 8'h02);
		cfg_mode <= 0;
		cfg_err_event <= 1;
		@(posedge core_clk);
		cfg_err_event <= 0;
		repeat (3) @(posedge core_clk);
		check({7'h0, host_irq}, 8'h00);
		wr(5'h01, 8'h00);
	endtask
	task automatic t_hold();
		wr(5'h01, 8'h18);
		t0 = cyc;
		fork
			wr(5'h04, 8'ha5);
			begin
				repeat (12) @(posedge core_clk);
				check({7'h0, host_ack}, 8'h00);
				cfg_serial_done <= 1;
				@(posedge core_clk);
				cfg_serial_done <= 0;
			end
		join
		check({7'h0, cyc - t0 > 13}, 8'h01);
		check(got_byte, 8'ha5);
		wr(5'h01, 8'h10);
		t0 = cyc;
		wr(5'h04, 8'h3c);
		check(8'(cyc - t0), 8'h03);
	endtask
	task automatic t_cfg();
		init_pin <= 1;
		wr(5'h01, 8'h01);
		cfg_mode <= 1;
		cfg_byte_req <= 1;
		@(posedge core_clk);
		cfg_byte_req <= 0;
		repeat (2) @(posedge core_clk);
		check({7'h0, host_irq}, 8'h01);
		rd(5'h03, 8'h56);
		wr(5'h04, 8'h00);
		rd(5'h03, 8'h54);
		cfg_chain_mode <= 0;
		cfg_byte_req <= 1;
		@(posedge core_clk);
		cfg_byte_req <= 0;
		repeat (2) @(posedge core_clk);
		check({7'h0, host_irq}, 8'h00);
		prog_active <= 1;
		@(posedge core_clk);
		prog_active <= 0;
		rd(5'h03, 8'h42);
		cfg_mode <= 0;
		cfg_chain_mode <= 1;
		wr(5'h01, 8'h00);
	endtask
	task automatic t_user();
		wr(5'h01, 8'h20);
		done_pin <= 1;
		repeat (8) @(posedge core_clk);
		check({7'h0, port_user_active}, 8'h01);
		wr(5'h01, 8'h00);
		repeat (2) @(posedge core_clk);
		check({7'h0, port_user_active}, 8'h00);
		cfg_stream_user_mode <= 1;
		repeat (2) @(posedge core_clk);
		check({7'h0, port_user_active}, 8'h01);
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1;
		@(posedge core_clk);
		t_regs();
		t_irq();
		t_hold();
		t_cfg();
		t_user();
		report_and_stop();
	end
endmodule
`default_nettype wire
